// >>> smbrb_pkg.sv
`default_nettype none
package smbrb_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices
    localparam logic [7:0] IDX_REV_VENDOR   = 8'h05;
    localparam logic [7:0] IDX_PART         = 8'h06;
    localparam logic [7:0] IDX_READBACK_LEN = 8'h07;

    ////////////////////////////////////////////////////////////////////////////
    // Field layout
    localparam int         REV_LSB       = 4;
    localparam int         VENDOR_LSB    = 0;
    localparam int         CLASS_LSB     = 6;
    localparam int         CODE_LSB      = 0;
    localparam int         LEN_W         = 5;
    localparam int         LEN_LSB       = 0;
    localparam logic [4:0] LEN_RESET     = 5'h08;

    ////////////////////////////////////////////////////////////////////////////
    // Bus addresses selected by the address strap
    localparam logic [6:0] ADDR_SADR0    = 7'h30;
    localparam logic [6:0] ADDR_SADR1    = 7'h32;

    ////////////////////////////////////////////////////////////////////////////
    // Bit counting and strap timing
    localparam logic [3:0] BYTE_BITS     = 4'h8;
    localparam logic [3:0] LAST_TX_BIT   = 4'h7;
    localparam logic [1:0] STRAP_CAPTURE = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK
    } smbrb_state_e;

    typedef enum logic [1:0] {
        RX_ADDR,
        RX_INDEX,
        RX_WCOUNT,
        RX_WDATA
    } smbrb_rx_e;

endpackage
`default_nettype wire

// >>> smbrb_sync.sv
`timescale 1ns/1ps
`default_nettype none
module smbrb_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    // Asynchronous in, synchronous out
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] stage1_ff;
    logic [W-1:0] stage2_ff;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            stage1_ff <= RST_VAL;
            stage2_ff <= RST_VAL;
        end else begin
            stage1_ff <= i_async;
            stage2_ff <= stage1_ff;
        end
    end

    assign o_sync = stage2_ff;

endmodule
`default_nettype wire

// >>> smbrb_regs.sv
// Contract
// (RL1) Index five is a read-only byte with a revision code above a vendor code, unchanged by writes.
// (RL2) Index six is a read-only byte with a two-bit part class above a six-bit part code.
// (RL3) Index seven holds a five-bit writable readback length in its low bits, upper bits reserved.
// (RL4) A block read returns as many data bytes as the readback length last written; the code sends it as the count byte, then data until the host nacks.
// (RL5) The readback length is eight after reset.
// (RL6) A block read sends the count first, then data from the written index; host acks each, ends with nack and stop.
// (RL7) Writes to the identity bytes or reserved bits are acknowledged but change nothing.
`timescale 1ns/1ps
`default_nettype none
module smbrb_regs
    import smbrb_pkg::*;
#(
    // Identity values, arbitrary
    parameter logic [3:0] REV_CODE    = 4'h3,
    parameter logic [3:0] VENDOR_CODE = 4'h9,
    parameter logic [1:0] PART_CLASS  = 2'h2,
    parameter logic [5:0] PART_CODE   = 6'h15
) (
    // Clock and reset
    input  wire logic                         i_sys_clk,
    input  wire logic                         i_rst_n,
    // Bus pins
    input  wire logic                         i_smb_clk,
    input  wire logic                         i_sda,
    output logic                              o_sda,
    output logic                              o_sda_oe,
    // Address strap
    input  wire logic                         i_sadr,
    // Status
    output logic [smbrb_pkg::LEN_W-1:0]       o_readback_len
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and bus condition detection

    logic [2:0]   pins_s;
    logic         sadr_s;
    logic         scl_s;
    logic         sda_s;
    logic         scl_d_ff;
    logic         sda_d_ff;
    logic         scl_rise;
    logic         scl_fall;
    logic         start_det;
    logic         stop_det;

    smbrb_sync #(
        .W       (3),
        .RST_VAL (3'h3)
    ) u_pin_sync (
        .i_clk   (i_sys_clk),
        .i_rst_n (i_rst_n),
        .i_async ({i_sadr, i_smb_clk, i_sda}),
        .o_sync  (pins_s)
    );

    assign sadr_s = pins_s[2];
    assign scl_s  = pins_s[1];
    assign sda_s  = pins_s[0];

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_d_ff;
    assign scl_fall  = ~scl_s & scl_d_ff;
    assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    assign stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

    ////////////////////////////////////////////////////////////////////////////
    // Address strap, caught once after reset release

    logic [1:0]   strap_cnt_ff;
    logic         sadr_ff;
    logic [6:0]   own_addr;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            strap_cnt_ff <= 2'h0;
            sadr_ff      <= 1'b0;
        end else if (strap_cnt_ff != STRAP_CAPTURE) begin
            strap_cnt_ff <= strap_cnt_ff + 2'h1;
            if (strap_cnt_ff + 2'h1 == STRAP_CAPTURE) begin
                sadr_ff <= sadr_s;
            end
        end
    end

    assign own_addr = sadr_ff ? ADDR_SADR1 : ADDR_SADR0;

    ////////////////////////////////////////////////////////////////////////////
    // Register read decode

    function automatic logic [7:0] reg_read(input logic [7:0]       idx,
                                            input logic [LEN_W-1:0] len);
        logic [7:0] val;
        val = 8'h00;
        case (idx)
            IDX_REV_VENDOR: begin
                val[REV_LSB +: 4]    = REV_CODE;                    // RL1
                val[VENDOR_LSB +: 4] = VENDOR_CODE;                 // RL1
            end
            IDX_PART: begin
                val[CLASS_LSB +: 2]  = PART_CLASS;                  // RL2
                val[CODE_LSB +: 6]   = PART_CODE;                   // RL2
            end
            IDX_READBACK_LEN: begin
                val[LEN_LSB +: LEN_W] = len;                        // RL3
            end
            default: begin
                val = 8'h00;
            end
        endcase
        return val;
    endfunction

    function automatic smbrb_rx_e next_rx(input smbrb_rx_e kind);
        smbrb_rx_e nk;
        nk = RX_WDATA;
        case (kind)
            RX_ADDR:   nk = RX_INDEX;
            RX_INDEX:  nk = RX_WCOUNT;
            RX_WCOUNT: nk = RX_WDATA;
            default:   nk = RX_WDATA;
        endcase
        return nk;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Protocol engine

    smbrb_state_e state_ff;
    smbrb_rx_e    rx_kind_ff;
    logic [3:0]   bitcnt_ff;
    logic [7:0]   shift_ff;
    logic [7:0]   tx_ff;
    logic [7:0]   index_ff;
    logic         read_ff;
    logic         host_nack_ff;
    logic         oe_ff;
    logic [LEN_W-1:0] len_ff;
    logic         byte_done;
    logic         addr_hit;
    logic         wr_en;
    logic [7:0]   rd_byte;
    logic [7:0]   count_byte;

    assign byte_done = (state_ff == ST_RX) & scl_fall & (bitcnt_ff == BYTE_BITS);
    assign count_byte = {{(8-LEN_W){1'b0}}, len_ff};
    assign addr_hit  = (shift_ff[7:1] == own_addr);
    assign wr_en     = byte_done & (rx_kind_ff == RX_WDATA);
    assign rd_byte   = reg_read(index_ff, len_ff);

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            state_ff     <= ST_IDLE;
            rx_kind_ff   <= RX_ADDR;
            bitcnt_ff    <= 4'h0;
            shift_ff     <= 8'h00;
            tx_ff        <= 8'h00;
            index_ff     <= 8'h00;
            read_ff      <= 1'b0;
            host_nack_ff <= 1'b0;
            oe_ff        <= 1'b0;
        end else if (start_det) begin
            state_ff   <= ST_RX;
            rx_kind_ff <= RX_ADDR;
            bitcnt_ff  <= 4'h0;
            oe_ff      <= 1'b0;
        end else if (stop_det) begin
            state_ff <= ST_IDLE;
            oe_ff    <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    oe_ff <= 1'b0;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        shift_ff  <= {shift_ff[6:0], sda_s};
                        bitcnt_ff <= bitcnt_ff + 4'h1;
                    end else if (byte_done) begin
                        bitcnt_ff <= 4'h0;
                        if (rx_kind_ff == RX_ADDR && !addr_hit) begin
                            state_ff <= ST_IDLE;
                        end else begin
                            state_ff <= ST_RX_ACK;
                            oe_ff    <= 1'b1;                       // RL7
                            if (rx_kind_ff == RX_ADDR) begin
                                read_ff <= shift_ff[0];
                            end
                            if (rx_kind_ff == RX_INDEX) begin
                                index_ff <= shift_ff;               // RL6
                            end
                            if (rx_kind_ff == RX_WDATA) begin
                                index_ff <= index_ff + 8'h01;
                            end
                        end
                    end
                end
                ST_RX_ACK: begin
                    if (scl_fall) begin
                        if (rx_kind_ff == RX_ADDR && read_ff) begin
                            // Count byte leads the block read
                            state_ff  <= ST_TX;
                            tx_ff     <= count_byte;                // RL4
                            oe_ff     <= ~count_byte[7];            // RL6
                            bitcnt_ff <= 4'h0;
                        end else begin
                            state_ff   <= ST_RX;
                            rx_kind_ff <= next_rx(rx_kind_ff);
                            oe_ff      <= 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bitcnt_ff == LAST_TX_BIT) begin
                            state_ff  <= ST_TX_ACK;
                            oe_ff     <= 1'b0;
                            bitcnt_ff <= 4'h0;
                        end else begin
                            tx_ff     <= {tx_ff[6:0], 1'b0};
                            oe_ff     <= ~tx_ff[6];
                            bitcnt_ff <= bitcnt_ff + 4'h1;
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        host_nack_ff <= sda_s;
                    end else if (scl_fall) begin
                        if (host_nack_ff) begin
                            state_ff <= ST_IDLE;                    // RL6
                            oe_ff    <= 1'b0;
                        end else begin
                            state_ff  <= ST_TX;                     // RL6
                            tx_ff     <= rd_byte;
                            oe_ff     <= ~rd_byte[7];
                            index_ff  <= index_ff + 8'h01;
                            bitcnt_ff <= 4'h0;
                        end
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                    oe_ff    <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Readback length register

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            len_ff <= LEN_RESET;                                    // RL5
        end else if (wr_en && index_ff == IDX_READBACK_LEN) begin
            len_ff <= shift_ff[LEN_LSB +: LEN_W];                   // RL3
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign o_sda          = 1'b0;
    assign o_sda_oe       = oe_ff;
    assign o_readback_len = len_ff;

endmodule
`default_nettype wire

// >>> smbrb_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module smbrb_regs_props (
    // Clock and reset
    input wire logic                       i_sys_clk,
    input wire logic                       i_rst_n,
    // Bus pins and strap
    input wire logic                       i_smb_clk,
    input wire logic                       i_sda,
    input wire logic                       o_sda,
    input wire logic                       o_sda_oe,
    input wire logic                       i_sadr,
    // Status
    input wire logic [smbrb_pkg::LEN_W-1:0] o_readback_len
);
    import smbrb_pkg::*;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////////////////////
    a_len_after_reset: assert property ($rose(i_rst_n) |-> o_readback_len == 5'h08)
        else $error("readback length not eight after reset");
    a_oe_after_reset: assert property ($rose(i_rst_n) |-> !o_sda_oe)
        else $error("data line driven after reset");
    a_sda_drive_low: assert property (o_sda == 1'b0)
        else $error("data line driven high");
    a_oe_moves_low: assert property ($changed(o_sda_oe) |-> !i_smb_clk && !$past(i_smb_clk, 2))
        else $error("data line changed outside clock low phase");
    a_oe_rise_holds: assert property ($rose(o_sda_oe) |=> o_sda_oe [*6])
        else $error("driven bit too short");
    a_oe_fall_holds: assert property ($fell(o_sda_oe) |=> !o_sda_oe [*6])
        else $error("released bit too short");
    a_len_idle_hold: assert property ((i_smb_clk && i_sda) [*8] |=> $stable(o_readback_len))
        else $error("readback length changed on idle bus");
endmodule
`default_nettype wire

// >>> smbrb_host.sv
`timescale 1ns/1ps
`default_nettype none
module smbrb_host (
    // Bus pins
    output var logic o_scl,
    output var logic o_sda,
    input  wire logic i_sda
);
    logic [7:0] rb [0:40];
    int         nak_cnt;
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
        nak_cnt = 0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // One clock period of 160 ns, data moved well after the falling edge
    task automatic bitx(input logic b, output logic r);
        #40 o_sda = b;
        #60 o_scl = 1'b1;
        #40 r = i_sda;
        #20 o_scl = 1'b0;
    endtask
    // Low phase long enough for the device to let go of an ack first
    task automatic start();
        #13 o_sda = 1'b1;
        #80 o_scl = 1'b1;
        #40 o_sda = 1'b0;
        #40 o_scl = 1'b0;
    endtask
    // Clock stands high between frames
    task automatic stop();
        #40 o_sda = 1'b0;
        #40 o_scl = 1'b1;
        #40 o_sda = 1'b1;
        #200;
    endtask
    task automatic xbyte(input logic [7:0] d, input logic ack, output logic [7:0] q);
        logic a;
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(ack, a);
        if (ack && a !== 1'b0) nak_cnt++;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [6:0] adr, input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        start();
        xbyte({adr, 1'b0}, 1'b1, q);
        xbyte(idx, 1'b1, q);
        xbyte(8'h01, 1'b1, q);
        xbyte(d, 1'b1, q);
        stop();
    endtask
    // Count byte lands in rb[0], data in rb[1..n]
    task automatic rd(input logic [6:0] adr, input logic [7:0] idx, input int n);
        logic [7:0] q;
        logic       a;
        start();
        xbyte({adr, 1'b0}, 1'b1, q);
        xbyte(idx, 1'b1, q);
        start();
        xbyte({adr, 1'b1}, 1'b1, q);
        for (int k = 0; k <= n; k++) begin
            for (int i = 7; i >= 0; i--) bitx(1'b1, rb[k][i]);
            bitx(k == n, a);
        end
        stop();
    endtask
endmodule
`default_nettype wire

// >>> smbrb_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module smbrb_regs_test;
    import smbrb_pkg::*;
    // Arbitrary identity values
    localparam logic [3:0] REV = 4'hC;
    localparam logic [3:0] VEN = 4'h5;
    localparam logic [1:0] CLS = 2'h1;
    localparam logic [5:0] COD = 6'h2A;
    localparam logic [7:0] B5  = {REV, VEN};
    localparam logic [7:0] B6  = {CLS, COD};
    localparam logic [6:0] ADR = ADDR_SADR1;
    logic       clk   = 1'b0;
    logic       rst_n = 1'b0;
    logic       sadr  = 1'b1;
    logic       scl;
    logic       sda_h;
    logic       sda_o;
    logic       oe;
    logic [4:0] len;
    wire logic  sda_w;
    int         error_cnt = 0;
    int         cmp_count = 0;
    always #10 clk = ~clk;
    assign sda_w = sda_h & (~oe | sda_o);
    ////////////////////////////////////////////////////////////////////////////
    smbrb_regs #(.REV_CODE(REV), .VENDOR_CODE(VEN), .PART_CLASS(CLS), .PART_CODE(COD)) u_dut (
        .i_sys_clk      (clk),
        .i_rst_n        (rst_n),
        .i_smb_clk      (scl),
        .i_sda          (sda_w),
        .o_sda          (sda_o),
        .o_sda_oe       (oe),
        .i_sadr         (sadr),
        .o_readback_len (len)
    );
    smbrb_host u_host (.o_scl(scl), .o_sda(sda_h), .i_sda(sda_w));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        results();
    end
    initial begin
        do_reset();
        chk({3'h0, len}, 8'h08);
        u_host.rd(ADR, IDX_REV_VENDOR, 3);
        chk(u_host.rb[0], 8'h08);
        chk(u_host.rb[1], B5);
        chk(u_host.rb[2], B6);
        chk(u_host.rb[3], 8'h08);
        u_host.wr(ADR, IDX_REV_VENDOR, ~B5);
        u_host.wr(ADR, IDX_PART, ~B6);
        u_host.wr(ADR, IDX_READBACK_LEN, 8'hE3);
        chk({3'h0, len}, 8'h03);
        u_host.rd(ADR, IDX_REV_VENDOR, 3);
        chk(u_host.rb[0], 8'h03);
        chk(u_host.rb[1], B5);
        chk(u_host.rb[2], B6);
        chk(u_host.rb[3], 8'h03);
        u_host.wr(ADR, IDX_READBACK_LEN, 8'h1F);
        u_host.rd(ADR, IDX_READBACK_LEN, 1);
        chk(u_host.rb[0], 8'h1F);
        chk(u_host.rb[1], 8'h1F);
        // Other strap address must be ignored
        u_host.wr(ADDR_SADR0, IDX_READBACK_LEN, 8'h02);
        chk({3'h0, len}, 8'h1F);
        chk(8'(u_host.nak_cnt), 8'h04);
        do_reset();
        chk({3'h0, len}, 8'h08);
        // Strap caught again, bytes past the bank read as zero
        u_host.rd(ADR, IDX_READBACK_LEN, 2);
        chk(u_host.rb[0], 8'h08);
        chk(u_host.rb[1], 8'h08);
        chk(u_host.rb[2], 8'h00);
        results();
    end
endmodule
bind smbrb_regs smbrb_regs_props u_props (
    .i_sys_clk      (i_sys_clk),
    .i_rst_n        (i_rst_n),
    .i_smb_clk      (i_smb_clk),
    .i_sda          (i_sda),
    .o_sda          (o_sda),
    .o_sda_oe       (o_sda_oe),
    .i_sadr         (i_sadr),
    .o_readback_len (o_readback_len)
);
`default_nettype wire
